/* File: src/sewc_pkg.sv */
// Notes on behaviour
// RQ1: fill_all_cmd writes one word to every address at once within 5 ms.
// RQ2: x16 fill_all_cmd frame: 8 address bits, 16 data bits, 27 clocks.
// RQ3: reset leaves the device write-disabled until write enable executes.
// RQ4: write enable holds until program_lock_cmd; then writes are ignored.
// RQ5: reads execute whether write is enabled or disabled.
// RQ6: host supplies all clocks after the sixth for enable and lock commands.
// RQ7: host should issue program_lock_cmd after each programming operation.
// RQ8: erase sets every bit of the addressed word to one.
// RQ9: erase starts at select fall after last address bit; status pollable.
// RQ10: clear_all_cmd sets all bits; starts at select fall after final clock.
// RQ11: write aborts if select drops before last data bit; then uncancellable.
// RQ12: an extra clock beyond frame length cancels the command at select fall.
// RQ13: erase commands cancel if select drops before the last address bit.
// RQ14: host should drop select while serial clock is low.
// RQ15: data output is high impedance except for status and read data.
// RQ16: after programming, select high shows status: low busy, high ready.
// RQ17: internal timer ends programming; next command only after it ends.
// RQ18: commands during busy are discarded; during ready they are accepted.
// RQ19: a start bit during ready status releases the data output.
// RQ20: host holds data input low and quiet while select is high and busy.
// RQ21: on the last address bit clock of a read a dummy zero is driven.
// RQ22: shared line: host keeps clock low or starts within 4 clocks.
// RQ23: first one after select rises is the start bit; leading zeros ignored.
// RQ24: two-bit opcode after start; code 00 plus top address bits extends it.
// RQ25: single write starts at select fall after the last data bit.
// RQ26: select low resets the command shift logic.
package sewc_pkg;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          PROG_TIME_MS  = 5;
	localparam int          PROG_CYCLES   =
		PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          SEL_LOW_NS    = 250;
	localparam int          SEL_LOW_CYC   =
		(SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TMR_W         = 18;
	localparam int          CNT_W         = 5;
	localparam int          LOW_W         = 5;
	localparam int          PIN_W         = 4;
	localparam int          MEM_WORDS     = 128;
	localparam logic [4:0]  N_LONG_X16    = 5'h1B;
	localparam logic [4:0]  N_SHORT_X16   = 5'h0B;
	localparam logic [4:0]  N_LONG_X8     = 5'h14;
	localparam logic [4:0]  N_SHORT_X8    = 5'h0C;
	localparam logic [4:0]  OP_END        = 5'h03;
	localparam logic [4:0]  BITS_X16      = 5'h10;
	localparam logic [4:0]  BITS_X8       = 5'h08;
	localparam logic [4:0]  CNT_MAX       = 5'h1F;
	localparam logic [1:0]  OP_EXT        = 2'h0;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_ERASE      = 2'h3;
	localparam logic [1:0]  EXT_LOCK      = 2'h0;
	localparam logic [1:0]  EXT_FILL      = 2'h1;
	localparam logic [1:0]  EXT_CLEAR     = 2'h2;
	localparam logic [1:0]  EXT_OPEN      = 2'h3;
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
	localparam logic [15:0] LANE_LO       = 16'h00FF;
	localparam logic [15:0] LANE_HI       = 16'hFF00;

	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
		logic wide;
	} sewc_pins_t;

	typedef enum logic [2:0] {
		CMD_READ, CMD_WRITE, CMD_FILL, CMD_CLEAR,
		CMD_ERASE, CMD_OPEN, CMD_LOCK
	} sewc_cmd_t;

	typedef enum logic [1:0] {
		ST_HUNT, ST_SHIFT, ST_READ
	} sewc_state_t;
endpackage

/* File: src/sewc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser, one stage pair per pin
module sewc_sync (
	input  wire logic                     i_core_clk, // core clock
	input  wire logic                     i_rst,      // async reset
	input  wire logic [sewc_pkg::PIN_W-1:0] i_raw,    // raw pins
	output logic      [sewc_pkg::PIN_W-1:0] o_sync    // synced pins
);
	logic [sewc_pkg::PIN_W-1:0] meta_q;

	genvar g;
	generate
		for (g = 0; g < sewc_pkg::PIN_W; g++) begin : g_bit
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_q[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta_q[g] <= i_raw[g];
					o_sync[g] <= meta_q[g];
				end
			end
		end
	endgenerate
endmodule

/* File: src/sewc_top.sv */
`timescale 1ns/1ps
module sewc_top #(
	parameter int PROG_CYCLES = sewc_pkg::PROG_CYCLES
) (
	input  wire logic i_core_clk,          // core clock, 50 MHz
	input  wire logic i_rst,               // async reset, high
	input  wire logic i_cs,                // chip select pin
	input  wire logic i_sk,                // serial clock pin
	input  wire logic i_di,                // serial data in pin
	input  wire logic i_word_width_select, // 1: 16-bit words
	output logic      o_do,                // serial data out
	output logic      o_do_oe              // data out drive enable
);
	// ==========================================================
	// pin sampling and edges
	sewc_pkg::sewc_pins_t pins_s;
	logic [sewc_pkg::PIN_W-1:0] pins_raw;
	logic [sewc_pkg::PIN_W-1:0] pins_v;
	logic                       cs_p_q;
	logic                       sk_p_q;

	assign pins_raw = {i_cs, i_sk, i_di, i_word_width_select};
	assign pins_s   = sewc_pkg::sewc_pins_t'(pins_v);

	sewc_sync u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_raw      (pins_raw),
		.o_sync     (pins_v)
	);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cs_p_q <= 1'b0;
			sk_p_q <= 1'b0;
		end else begin
			cs_p_q <= pins_s.cs;
			sk_p_q <= pins_s.sk;
		end
	end

	wire sk_rise = pins_s.sk & ~sk_p_q;
	wire cs_fall = ~pins_s.cs & cs_p_q;
	wire cs_rise = pins_s.cs & ~cs_p_q;
	wire wide    = pins_s.wide;

	// ==========================================================
	// frame decode
	sewc_pkg::sewc_state_t state_q;
	sewc_pkg::sewc_cmd_t   cmd;
	logic [4:0]  cnt_q;
	logic [1:0]  op_q;
	logic [8:0]  addr_q;
	logic [15:0] data_q;
	logic        wen_q;
	logic        busy_q;
	logic        status_q;
	logic        arm_q;

	wire [4:0] a0_cnt   = wide ? sewc_pkg::N_SHORT_X16
	                           : sewc_pkg::N_SHORT_X8;
	wire [1:0] top2     = wide ? addr_q[7:6] : addr_q[8:7];
	wire [8:0] addr_nx  = {addr_q[7:0], pins_s.di};
	wire       is_ext   = op_q == sewc_pkg::OP_EXT;
	wire       is_long  = (op_q == sewc_pkg::OP_READ)
	                    | (op_q == sewc_pkg::OP_WRITE)
	                    | (is_ext & (top2 == sewc_pkg::EXT_FILL));
	wire [4:0] n_len    = is_long
		? (wide ? sewc_pkg::N_LONG_X16 : sewc_pkg::N_LONG_X8)
		: (wide ? sewc_pkg::N_SHORT_X16 : sewc_pkg::N_SHORT_X8);

	// RQ24
	assign cmd = (op_q == sewc_pkg::OP_READ)  ? sewc_pkg::CMD_READ  :
	             (op_q == sewc_pkg::OP_WRITE) ? sewc_pkg::CMD_WRITE :
	             (op_q == sewc_pkg::OP_ERASE) ? sewc_pkg::CMD_ERASE :
	             (top2 == sewc_pkg::EXT_FILL)  ? sewc_pkg::CMD_FILL  :
	             (top2 == sewc_pkg::EXT_CLEAR) ? sewc_pkg::CMD_CLEAR :
	             (top2 == sewc_pkg::EXT_OPEN)  ? sewc_pkg::CMD_OPEN  :
	                                             sewc_pkg::CMD_LOCK;

	wire in_shift = state_q == sewc_pkg::ST_SHIFT;
	wire in_read  = state_q == sewc_pkg::ST_READ;
	// RQ23 RQ18
	wire start_seen = (state_q == sewc_pkg::ST_HUNT) & pins_s.cs
	                & sk_rise & pins_s.di & ~busy_q;
	wire shift_en = in_shift & sk_rise;
	wire in_op    = cnt_q < sewc_pkg::OP_END;
	wire in_addr  = ~in_op & (cnt_q < a0_cnt);
	// RQ21 RQ5
	wire rd_go    = shift_en & (op_q == sewc_pkg::OP_READ)
	              & (cnt_q == a0_cnt - 5'h01);
	// RQ11 RQ12 RQ13
	wire frame_ok = in_shift & (cnt_q == n_len);
	wire wr_class = (cmd == sewc_pkg::CMD_WRITE)
	              | (cmd == sewc_pkg::CMD_FILL)
	              | (cmd == sewc_pkg::CMD_CLEAR)
	              | (cmd == sewc_pkg::CMD_ERASE);
	// RQ4 RQ9 RQ10 RQ25
	wire prog_start = cs_fall & frame_ok & wr_class & wen_q & ~busy_q;
	wire ctl_start  = cs_fall & frame_ok
	                & ((cmd == sewc_pkg::CMD_OPEN)
	                 | (cmd == sewc_pkg::CMD_LOCK));

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= sewc_pkg::ST_HUNT;
			cnt_q   <= 5'h00;
		end else if (!pins_s.cs) begin
			state_q <= sewc_pkg::ST_HUNT; // RQ26
			cnt_q   <= 5'h00;             // RQ26
		end else begin
			case (state_q)
				sewc_pkg::ST_HUNT: begin
					if (start_seen) begin
						state_q <= sewc_pkg::ST_SHIFT;
						cnt_q   <= 5'h01;
					end
				end
				sewc_pkg::ST_SHIFT: begin
					if (sk_rise && cnt_q != sewc_pkg::CNT_MAX) begin
						cnt_q <= cnt_q + 5'h01; // RQ12
					end
					if (rd_go) begin
						state_q <= sewc_pkg::ST_READ;
					end
				end
				sewc_pkg::ST_READ: begin
					state_q <= sewc_pkg::ST_READ;
				end
				default: begin
					state_q <= sewc_pkg::ST_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			op_q   <= 2'h0;
			addr_q <= 9'h000;
			data_q <= 16'h0000;
		end else if (start_seen) begin
			op_q   <= 2'h0;
			addr_q <= 9'h000;
			data_q <= 16'h0000;
		end else if (shift_en) begin
			if (in_op) begin
				op_q <= {op_q[0], pins_s.di};
			end else if (in_addr) begin
				addr_q <= addr_nx;
			end else if (cnt_q < n_len) begin
				data_q <= {data_q[14:0], pins_s.di}; // RQ2
			end
		end
	end

	// ==========================================================
	// memory array, one update process per word
	logic [15:0] mem_q [sewc_pkg::MEM_WORDS];

	function automatic logic [15:0] word_at(input logic [7:0] a,
	                                        input logic       w);
		logic [15:0] m;
		m = w ? mem_q[a[6:0]] : mem_q[a[7:1]];
		if (w) begin
			word_at = m;
		end else begin
			word_at = a[0] ? {m[15:8], 8'h00} : {m[7:0], 8'h00};
		end
	endfunction

	wire       all_cmd = (cmd == sewc_pkg::CMD_FILL)
	                   | (cmd == sewc_pkg::CMD_CLEAR);
	wire       ers_cmd = (cmd == sewc_pkg::CMD_CLEAR)
	                   | (cmd == sewc_pkg::CMD_ERASE);
	wire [6:0] widx    = wide ? addr_q[6:0] : addr_q[7:1];
	// RQ8 RQ10
	wire [15:0] wval   = ers_cmd ? sewc_pkg::ERASED_WORD :
	                     wide    ? data_q :
	                               {data_q[7:0], data_q[7:0]};
	wire [15:0] wmask  = (wide | all_cmd) ? sewc_pkg::ERASED_WORD :
	                     addr_q[0]        ? sewc_pkg::LANE_HI :
	                                        sewc_pkg::LANE_LO;

	genvar g;
	generate
		for (g = 0; g < sewc_pkg::MEM_WORDS; g++) begin : g_word
			// RQ1
			wire hit = prog_start & (all_cmd | (widx == 7'(g)));
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					mem_q[g] <= sewc_pkg::ERASED_WORD;
				end else if (hit) begin
					mem_q[g] <= (mem_q[g] & ~wmask) | (wval & wmask);
				end
			end
		end
	endgenerate

	// ==========================================================
	// read shifter with address auto increment
	logic [7:0]  rd_addr_q;
	logic [15:0] rd_sh_q;
	logic [4:0]  rd_left_q;

	wire [4:0] wbits   = wide ? sewc_pkg::BITS_X16 : sewc_pkg::BITS_X8;
	wire       rd_step = in_read & pins_s.cs & sk_rise;
	wire [7:0] rd_inc  = rd_addr_q + 8'h01;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_addr_q <= 8'h00;
			rd_sh_q   <= 16'h0000;
			rd_left_q <= 5'h00;
		end else if (rd_go) begin
			rd_addr_q <= addr_nx[7:0];
			rd_sh_q   <= word_at(addr_nx[7:0], wide);
			rd_left_q <= wbits;
		end else if (rd_step) begin
			if (rd_left_q == 5'h01) begin
				rd_addr_q <= rd_inc;
				rd_sh_q   <= word_at(rd_inc, wide);
				rd_left_q <= wbits;
			end else begin
				rd_sh_q   <= {rd_sh_q[14:0], 1'b0};
				rd_left_q <= rd_left_q - 5'h01;
			end
		end
	end

	// ==========================================================
	// write enable and programming timer
	logic [sewc_pkg::TMR_W-1:0] tmr_q;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wen_q <= 1'b0; // RQ3
		end else if (ctl_start) begin
			wen_q <= cmd == sewc_pkg::CMD_OPEN; // RQ4
		end
	end

	// RQ17
	wire tmr_end = tmr_q == sewc_pkg::TMR_W'(PROG_CYCLES - 1);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q <= 1'b0;
			tmr_q  <= '0;
		end else if (prog_start) begin
			busy_q <= 1'b1;
			tmr_q  <= '0;
		end else if (busy_q) begin
			busy_q <= ~tmr_end;
			tmr_q  <= tmr_q + 1'b1;
		end
	end

	// ==========================================================
	// ready/busy status
	logic [sewc_pkg::LOW_W-1:0] lowc_q;

	wire low_ok = lowc_q == sewc_pkg::LOW_W'(sewc_pkg::SEL_LOW_CYC);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			lowc_q <= '0;
		end else if (pins_s.cs) begin
			lowc_q <= '0;
		end else if (!low_ok) begin
			lowc_q <= lowc_q + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			arm_q    <= 1'b0;
			status_q <= 1'b0;
		end else begin
			if (prog_start) begin
				arm_q <= 1'b1;
			end else if (start_seen) begin
				arm_q <= 1'b0;
			end
			if (!pins_s.cs || start_seen) begin
				status_q <= 1'b0; // RQ19
			end else if (cs_rise) begin
				status_q <= arm_q & low_ok; // RQ16
			end
		end
	end

	// ==========================================================
	// data output
	wire stat_live = status_q & pins_s.cs & ~start_seen;
	wire rd_live   = in_read & pins_s.cs;
	// RQ15
	wire oe_d = rd_go | rd_live | stat_live;
	// RQ21 RQ16
	wire do_d = rd_go     ? 1'b0 :
	            rd_live   ? (rd_step ? rd_sh_q[15] : o_do) :
	            stat_live ? ~busy_q : 1'b0;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_do    <= 1'b0;
			o_do_oe <= 1'b0;
		end else begin
			o_do    <= do_d;
			o_do_oe <= oe_d;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	chk_out_hiz: assert property ( // RQ15
		!(rd_go || rd_live || stat_live) |=> !o_do_oe)
		else $error("data out driven outside status or read");
	chk_busy_low: assert property ( // RQ16
		stat_live && busy_q |=> o_do_oe && !o_do)
		else $error("busy status not low");
	chk_ready_high: assert property ( // RQ16
		stat_live && !busy_q |=> o_do_oe && o_do)
		else $error("ready status not high");
	chk_prog_locked: assert property ( // RQ4
		prog_start |-> wen_q)
		else $error("programming started while locked");
	chk_busy_len: assert property ( // RQ17
		$fell(busy_q) |-> $past(tmr_q) == sewc_pkg::TMR_W'(PROG_CYCLES - 1))
		else $error("programming period wrong length");
	chk_start_drop: assert property ( // RQ19
		status_q && start_seen |=> !status_q ##1 !o_do_oe)
		else $error("start bit did not release status");
	chk_busy_ignore: assert property ( // RQ18
		busy_q && state_q == sewc_pkg::ST_HUNT
		|=> state_q == sewc_pkg::ST_HUNT)
		else $error("command accepted while busy");
	chk_short_cancel: assert property ( // RQ11
		cs_fall && cnt_q != n_len
		|-> !prog_start && !ctl_start ##1 $stable(wen_q))
		else $error("command ran with wrong clock count");
	chk_dummy_zero: assert property ( // RQ21
		rd_go |=> o_do_oe && !o_do)
		else $error("no dummy zero before read data");
	chk_frame_reset: assert property ( // RQ26
		!pins_s.cs |=> cnt_q == 5'h00 && state_q == sewc_pkg::ST_HUNT)
		else $error("frame logic not cleared by select low");
	chk_erase_ones: assert property ( // RQ8
		prog_start && ers_cmd && wide |=> mem_q[$past(widx)] == 16'hFFFF)
		else $error("erased word not all ones");
endmodule

/* File: verification/sewc_host_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// host side of the three-wire link
module sewc_host_model (
	input  wire logic        i_do,     // device data out
	input  wire logic        i_do_oe,  // device drive enable
	output logic             o_cs,     // chip select
	output logic             o_sk,     // serial clock
	output logic             o_di,     // data to device
	output logic [16:0]      o_seen,   // sampled word or status
	output logic             o_seen_v  // strobe per sampled result
);
	logic        do_w;
	logic [16:0] sh;

	// a released data out line sits at its pull-up level
	assign do_w = i_do_oe ? i_do : 1'b1;

	initial begin
		o_cs     = 1'b0;
		o_sk     = 1'b0;
		o_di     = 1'b0;
		o_seen   = '0;
		o_seen_v = 1'b0;
		sh       = '0;
	end

	// select moves only while the clock is low, then keeps its level
	// longer than the minimum low time
	task automatic sel(input logic v);
		o_cs = v;
		// data in rests low and the clock stands still between frames
		o_di = 1'b0;
		#400;
	endtask

	// every clock of the frame is supplied; data out is sampled midway through
	// the low phase, after the device has answered the rising edge
	task automatic bits(input int n, input logic [31:0] v);
		for (int i = n - 1; i >= 0; i--) begin
			o_di = v[i];
			#40;
			o_sk = ~o_sk;
			#80;
			o_sk = ~o_sk;
			#40;
			sh = {sh[15:0], do_w};
		end
	endtask

	task automatic report(input logic [16:0] v);
		o_seen   = v;
		o_seen_v = 1'b1;
		o_seen_v <= #1 1'b0;
	endtask

	task automatic status();
		report({15'h0, i_do_oe, i_do});
	endtask

	task automatic take();
		report(sh);
	endtask
endmodule

/* File: verification/sewc_top_tb.sv */
`timescale 1ns/1ps
module sewc_top_tb;
	localparam int          PROG  = 100;
	localparam logic [10:0] OPEN  = 11'h4C0;
	localparam logic [10:0] LOCK  = 11'h400;
	localparam logic [10:0] CLEAR = 11'h480;
	localparam logic [10:0] FILL  = 11'h440;

	logic        clk;
	logic        rst;
	logic        ww;
	logic        cs;
	logic        sk;
	logic        di;
	logic        dout;
	logic        dout_oe;
	logic [16:0] seen;
	logic        seen_v;
	logic [16:0] q[$];
	logic [16:0] e;
	logic [15:0] d0;
	logic [15:0] d1;
	int          seed;
	int          n_fail;
	int          tests_run;
	int          cyc;

	sewc_top #(.PROG_CYCLES(PROG)) i_sewc_top (
		.i_core_clk          (clk),
		.i_rst               (rst),
		.i_cs                (cs),
		.i_sk                (sk),
		.i_di                (di),
		.i_word_width_select (ww),
		.o_do                (dout),
		.o_do_oe             (dout_oe)
	);

	sewc_host_model i_sewc_host_model (
		.i_do     (dout),
		.i_do_oe  (dout_oe),
		.o_cs     (cs),
		.o_sk     (sk),
		.o_di     (di),
		.o_seen   (seen),
		.o_seen_v (seen_v)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ======================================================================
	// checking
	task automatic chk(input logic [16:0] s, input logic [16:0] x);
		tests_run++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected do_word expected %h seen %h", x, s);
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge seen_v) begin
		e = q.size() > 0 ? q.pop_front() : 'x;
		chk(seen, e);
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			results();
		end
	end

	// ======================================================================
	// host operations
	task automatic sts(input logic [1:0] v);
		q.push_back({15'h0, v});
		i_sewc_host_model.status();
	endtask

	task automatic cmd(input int n, input logic [31:0] f);
		i_sewc_host_model.sel(1'b1);
		i_sewc_host_model.bits(n, f);
		i_sewc_host_model.sel(1'b0);
	endtask

	// wait whole cycles, then step off the edge that the pins are sampled on
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// programming command, then busy, ready and release by a start bit
	task automatic prog(input int n, input logic [31:0] f);
		cmd(n, f);
		i_sewc_host_model.sel(1'b1);
		sts(2'b10);
		cycles(PROG + 10);
		sts(2'b11);
		i_sewc_host_model.bits(1, 32'h1);
		sts(2'b00);
		i_sewc_host_model.sel(1'b0);
	endtask

	// x8 reads also see the released line during the address bits
	task automatic rd(input logic [8:0] a, input logic [15:0] d,
		input logic x8);
		i_sewc_host_model.sel(1'b1);
		if (x8) begin
			q.push_back({8'hFF, 1'b0, d[7:0]});
			i_sewc_host_model.bits(12, {3'b110, a});
			i_sewc_host_model.bits(8, 32'h0);
		end else begin
			q.push_back({1'b0, d});
			i_sewc_host_model.bits(11, {3'b110, a[7:0]});
			i_sewc_host_model.bits(16, 32'h0);
		end
		i_sewc_host_model.take();
		i_sewc_host_model.sel(1'b0);
	endtask

	// ======================================================================
	// stimulus
	initial begin
		seed = 32'h253a_0fad;
		n_fail = 0;
		tests_run = 0;
		cyc = 0;
		rst = 1'b1;
		ww = 1'b1;
		repeat (6) @(posedge clk);
		#2 rst = 1'b0;
		d0 = 16'($random(seed));
		d1 = 16'($random(seed));
		cycles(4);
		sts(2'b00);
		cmd(27, {3'b101, 8'h05, d0});
		rd(9'h005, 16'hFFFF, 1'b0);
		cmd(11, OPEN);
		prog(27, {3'b101, 8'h05, d0});
		rd(9'h005, d0, 1'b0);
		// short write, write with an extra clock, short erase
		cmd(26, {3'b101, 8'h05, d1} >> 1);
		cmd(28, {3'b101, 8'h05, d1, 1'b0});
		cmd(10, {3'b111, 8'h05} >> 1);
		rd(9'h005, d0, 1'b0);
		prog(11, {3'b111, 8'h05});
		rd(9'h005, 16'hFFFF, 1'b0);
		prog(27, {FILL, d1});
		rd(9'h000, d1, 1'b0);
		rd(9'h07F, d1, 1'b0);
		@(posedge clk);
		#2 ww = ~ww;
		rd(9'h0FF, {8'h00, d1[15:8]}, 1'b1);
		rd(9'h0FE, {8'h00, d1[7:0]}, 1'b1);
		// byte write to the high lane of word 3
		prog(20, {3'b101, 9'h007, d0[7:0]});
		rd(9'h007, {8'h00, d0[7:0]}, 1'b1);
		@(posedge clk);
		#2 ww = ~ww;
		rd(9'h003, {d0[7:0], d1[7:0]}, 1'b0);
		// second write lands while the first is still programming
		cmd(27, {3'b101, 8'h03, d0});
		cmd(27, {3'b101, 8'h04, 16'h0000});
		cycles(PROG + 10);
		rd(9'h003, d0, 1'b0);
		rd(9'h004, d1, 1'b0);
		prog(11, CLEAR);
		rd(9'h004, 16'hFFFF, 1'b0);
		cmd(11, LOCK);
		cmd(27, {3'b101, 8'h04, d0});
		cmd(11, {3'b111, 8'h04});
		cycles(PROG + 10);
		rd(9'h004, 16'hFFFF, 1'b0);
		results();
	end
endmodule
